// file: inc/cbd_pkg.sv
// Constants for the channel 2 and bias drive register bank
package cbd_pkg;
   // ==========================================
   // Register indices, byte address = 4 * index
   localparam logic [7:0] CBD_IDX_CH2 = 8'h05;
   localparam logic [7:0] CBD_IDX_BIAS = 8'h06;
   localparam logic [7:0] CBD_IDX_MCLK = 8'h10;
   localparam logic [7:0] CBD_IDX_STAT = 8'h11;
   localparam int CBD_ADDR_W = 8;
   localparam logic [7:0] CBD_RST_VAL = 8'h00;
   // ==========================================
   // Field positions
   localparam int CBD_PD_BIT = 7;
   localparam int CBD_GAIN_LO = 4;
   localparam int CBD_MUX_LO = 0;
   localparam int CBD_CHOP_LO = 6;
   localparam int CBD_BUFPWR_BIT = 5;
   localparam int CBD_LOFF_BIT = 4;
   localparam int CBD_B2N_BIT = 3;
   localparam int CBD_B2P_BIT = 2;
   localparam int CBD_B1N_BIT = 1;
   localparam int CBD_B1P_BIT = 0;
   localparam int CBD_DIVSEL_BIT = 0;
   // ==========================================
   // Input select codes
   localparam logic [3:0] CBD_MUX_SHORT = 4'h1;
   localparam logic [3:0] CBD_MUX_BPOS = 4'h6;
   localparam logic [3:0] CBD_MUX_BNEG = 4'h7;
   localparam logic [3:0] CBD_MUX_BBOTH = 4'h8;
   localparam logic [3:0] CBD_MUX_THIRD = 4'h9;
   localparam int CBD_MUX_CODES = 10;
   // ==========================================
   // Clock division
   localparam logic [4:0] CBD_MOD_DIV_LO = 5'h04;
   localparam logic [4:0] CBD_MOD_DIV_HI = 5'h10;
   localparam logic [1:0] CBD_CHOP_16 = 2'h0;
   localparam logic [1:0] CBD_CHOP_2 = 2'h2;
   localparam logic [1:0] CBD_CHOP_4 = 2'h3;
   // ==========================================
   // Bus answers
   localparam logic [1:0] CBD_RESP_OKAY = 2'h0;
   localparam logic [1:0] CBD_RESP_SLVERR = 2'h2;
endpackage

// file: rtl/cbd_config_regs.sv
// Channel 2 settings and bias drive sense registers behind AXI4-Lite
// What this block does
// - Channel 2 settings register sits at index 0x05.
// - Bit 7 powers channel 2 down; 0 is normal, reset value.
// - Bits 6:4 choose gain 6,1,2,3,4,8,12 for codes 000 to 110.
// - Bits 3:0 codes 0000-0101 select normal, short, bias, supply, temp, test.
// - Codes 0110/0111/1000 tie bias input pin to positive, negative, both.
// - Code 1001 routes third electrode pair to channel 2; 1010 reserved.
// - Bias drive sense register sits at index 0x06.
// - Bits 7:6 set chop rate: modulator clock /16, reserved, /2, /4.
// - Bit 5 powers the bias drive buffer; 0 is off at reset.
// - Bit 4 enables bias lead-off sensing; 0 is off at reset.
// - Bit 3 feeds channel 2 negative electrode into bias derivation.
// - Bit 2 feeds channel 2 positive electrode into bias derivation.
// - Bit 1 feeds channel 1 negative electrode into bias derivation.
// - Bit 0 feeds channel 1 positive electrode into bias derivation.
// - Modulator clock is input clock /4, or /16 with divider select set.
`timescale 1ns/1ps
`default_nettype none
module cbd_config_regs (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [cbd_pkg::CBD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [cbd_pkg::CBD_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic chan2_powerdown,
   output logic [3:0] chan2_gain,
   output logic [cbd_pkg::CBD_MUX_CODES-1:0] chan2_mux_onehot,
   output logic chan2_pos_to_bias_pin,
   output logic chan2_neg_to_bias_pin,
   output logic chan2_route_third_pair,
   output logic bias_buffer_power_on,
   output logic bias_leadoff_sense_enable,
   output logic bias_from_ch2_negative,
   output logic bias_from_ch2_positive,
   output logic bias_from_ch1_negative,
   output logic bias_from_ch1_positive,
   output logic modulator_clock,
   output logic chop_clock
);
   import cbd_pkg::*;

   // ==========================================
   // Helpers
   // Word index of a byte address
   function automatic logic [7:0] word_idx(input logic [CBD_ADDR_W-1:0] a);
      word_idx = {2'h0, a[CBD_ADDR_W-1:2]};
   endfunction
   // Gain value; 111 is undefined and reads as 0
   function automatic logic [3:0] gain_of(input logic [2:0] c);
      case (c)
         3'h0: gain_of = 4'h6;
         3'h1: gain_of = 4'h1;
         3'h2: gain_of = 4'h2;
         3'h3: gain_of = 4'h3;
         3'h4: gain_of = 4'h4;
         3'h5: gain_of = 4'h8;
         3'h6: gain_of = 4'hc;
         default: gain_of = 4'h0;
      endcase
   endfunction
   // Half chop period in modulator ticks; 0 stops the chop clock
   function automatic logic [3:0] chop_half(input logic [1:0] c);
      case (c)
         CBD_CHOP_16: chop_half = 4'h8;
         CBD_CHOP_2: chop_half = 4'h1;
         CBD_CHOP_4: chop_half = 4'h2;
         default: chop_half = 4'h0;
      endcase
   endfunction

   // ==========================================
   // Register state
   logic [7:0] ch2_reg, ch2_next;
   logic [7:0] bias_reg, bias_next;
   logic divsel_reg, divsel_next, wstrb0_reg, wstrb0_next, do_write;
   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic [7:0] aw_idx_reg, aw_idx_next;
   logic [7:0] wdata_reg, wdata_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [7:0] rd_idx;
   // Ready only while no write is parked, so bresp stays one per write
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign rd_idx = word_idx(s_axi_araddr);
   // Bus and register next state
   always_comb begin
      ch2_next = ch2_reg;
      bias_next = bias_reg;
      divsel_next = divsel_reg;
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      aw_idx_next = aw_idx_reg;
      wdata_next = wdata_reg;
      wstrb0_next = wstrb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      // Address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         aw_idx_next = word_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         wdata_next = s_axi_wdata[7:0];
         wstrb0_next = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = CBD_RESP_OKAY;
         // Bytes other than lane 0 hold nothing, so only lane 0 counts
         case (aw_idx_reg)
            CBD_IDX_CH2: if (wstrb0_reg) ch2_next = wdata_reg;
            CBD_IDX_BIAS: if (wstrb0_reg) bias_next = wdata_reg;
            CBD_IDX_MCLK: if (wstrb0_reg) divsel_next = wdata_reg[CBD_DIVSEL_BIT];
            CBD_IDX_STAT: ;
            default: bresp_next = CBD_RESP_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      // Reads only copy state out, never alter it
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = CBD_RESP_OKAY;
         case (rd_idx)
            CBD_IDX_CH2: rdata_next = ch2_reg;
            CBD_IDX_BIAS: rdata_next = bias_reg;
            CBD_IDX_MCLK: rdata_next = {7'h00, divsel_reg};
            CBD_IDX_STAT: rdata_next = {6'h00, chop_clock, modulator_clock};
            default: begin
               rdata_next = 8'h00;
               rresp_next = CBD_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ch2_reg <= CBD_RST_VAL;
         bias_reg <= CBD_RST_VAL;
         divsel_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= CBD_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rresp_reg <= CBD_RESP_OKAY;
      end else begin
         ch2_reg <= ch2_next;
         bias_reg <= bias_next;
         divsel_reg <= divsel_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         aw_idx_reg <= aw_idx_next;
         wdata_reg <= wdata_next;
         wstrb0_reg <= wstrb0_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = {24'h000000, rdata_reg};
   assign s_axi_rresp = rresp_reg;

   // ==========================================
   // Decoded controls, one flop after the register
   logic [17:0] ctl_reg, ctl_next;
   logic [3:0] mux;
   // Reserved select codes leave every route off
   always_comb begin
      mux = ch2_reg[CBD_MUX_LO +: 4];
      ctl_next = 18'h0;
      ctl_next[17] = ch2_reg[CBD_PD_BIT];
      ctl_next[16:13] = gain_of(ch2_reg[CBD_GAIN_LO +: 3]);
      if (mux < 4'(CBD_MUX_CODES))
         ctl_next[4'(mux)] = 1'b1;
      ctl_next[10] = (mux == CBD_MUX_BPOS) || (mux == CBD_MUX_BBOTH);
      ctl_next[11] = (mux == CBD_MUX_BNEG) || (mux == CBD_MUX_BBOTH);
      ctl_next[12] = (mux == CBD_MUX_THIRD);
   end
   // Decoded controls settle one edge after the register write
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         ctl_reg <= 18'h0;
      else
         ctl_reg <= ctl_next;
   end
   assign chan2_powerdown = ctl_reg[17];
   assign chan2_gain = ctl_reg[16:13];
   assign chan2_mux_onehot = ctl_reg[CBD_MUX_CODES-1:0];
   assign chan2_pos_to_bias_pin = ctl_reg[10];
   assign chan2_neg_to_bias_pin = ctl_reg[11];
   assign chan2_route_third_pair = ctl_reg[12];
   // Bias fields drive straight from the register flops
   assign bias_buffer_power_on = bias_reg[CBD_BUFPWR_BIT];
   assign bias_leadoff_sense_enable = bias_reg[CBD_LOFF_BIT];
   assign bias_from_ch2_negative = bias_reg[CBD_B2N_BIT];
   assign bias_from_ch2_positive = bias_reg[CBD_B2P_BIT];
   assign bias_from_ch1_negative = bias_reg[CBD_B1N_BIT];
   assign bias_from_ch1_positive = bias_reg[CBD_B1P_BIT];

   // ==========================================
   // Modulator and chop clock dividers
   logic [4:0] mod_cnt_reg, mod_cnt_next;
   logic [3:0] chop_cnt_reg, chop_cnt_next;
   logic mclk_reg, mclk_next, chop_reg, chop_next, mod_tick;
   logic [4:0] mod_div;
   logic [3:0] half;
   // Divider change takes effect at once, mid period; a count already past the new end wraps on the next edge
   always_comb begin
      mod_div = divsel_reg ? CBD_MOD_DIV_HI : CBD_MOD_DIV_LO;
      half = chop_half(bias_reg[CBD_CHOP_LO +: 2]);
      mod_tick = (mod_cnt_reg >= mod_div - 5'h01);
      mod_cnt_next = mod_tick ? 5'h00 : mod_cnt_reg + 5'h01;
      mclk_next = (mod_cnt_next < (mod_div >> 1));
      chop_cnt_next = chop_cnt_reg;
      chop_next = chop_reg;
      if (half == 4'h0) begin
         chop_cnt_next = 4'h0; // Reserved rate holds chop clock still
      end else if (mod_tick) begin
         if (chop_cnt_reg >= half - 4'h1) begin
            chop_cnt_next = 4'h0;
            chop_next = !chop_reg;
         end else begin
            chop_cnt_next = chop_cnt_reg + 4'h1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mod_cnt_reg <= 5'h00;
         chop_cnt_reg <= 4'h0;
         mclk_reg <= 1'b1;
         chop_reg <= 1'b0;
      end else begin
         mod_cnt_reg <= mod_cnt_next;
         chop_cnt_reg <= chop_cnt_next;
         mclk_reg <= mclk_next;
         chop_reg <= chop_next;
      end
   end
   assign modulator_clock = mclk_reg;
   assign chop_clock = chop_reg;

   // ==========================================
   // Checks
   property p_ch2_write;
      @(posedge sys_clk) disable iff (sys_rst)
      do_write && aw_idx_reg == CBD_IDX_CH2 && wstrb0_reg |=> ch2_reg == $past(wdata_reg);
   endproperty
   a_ch2_write: assert property (p_ch2_write) else $error("ch2 write lost");
   property p_pd;
      @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> chan2_powerdown == $past(ch2_reg[CBD_PD_BIT]);
   endproperty
   a_pd: assert property (p_pd) else $error("power-down not driven");
   property p_gain6;
      @(posedge sys_clk) disable iff (sys_rst)
      ch2_reg[CBD_GAIN_LO +: 3] == 3'h0 |=> chan2_gain == 4'h6;
   endproperty
   a_gain6: assert property (p_gain6) else $error("gain code 000 not 6");
   property p_short;
      @(posedge sys_clk) disable iff (sys_rst)
      ch2_reg[3:0] == CBD_MUX_SHORT |=> chan2_mux_onehot == 10'h002;
   endproperty
   a_short: assert property (p_short) else $error("short select wrong");
   property p_both;
      @(posedge sys_clk) disable iff (sys_rst)
      ch2_reg[3:0] == CBD_MUX_BBOTH |=> chan2_pos_to_bias_pin && chan2_neg_to_bias_pin;
   endproperty
   a_both: assert property (p_both) else $error("bias both not driven");
   property p_third;
      @(posedge sys_clk) disable iff (sys_rst)
      $past(ch2_reg[3:0]) != CBD_MUX_THIRD |-> !chan2_route_third_pair;
   endproperty
   a_third: assert property (p_third) else $error("third pair misrouted");
   property p_bias_write;
      @(posedge sys_clk) disable iff (sys_rst)
      do_write && aw_idx_reg == CBD_IDX_BIAS && wstrb0_reg
         |=> bias_buffer_power_on == $past(wdata_reg[CBD_BUFPWR_BIT]);
   endproperty
   a_bias_write: assert property (p_bias_write) else $error("buffer power lost");
   property p_readback;
      @(posedge sys_clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && rd_idx == CBD_IDX_CH2
         |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(ch2_reg);
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");
   property p_rhold;
      @(posedge sys_clk) disable iff (sys_rst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_mod4;
      @(posedge sys_clk) disable iff (sys_rst)
      !divsel_reg && mod_tick ##1 !divsel_reg [*4] |-> mod_tick;
   endproperty
   a_mod4: assert property (p_mod4) else $error("modulator not /4");
endmodule
`default_nettype wire

// file: dv/tb_cbd_config_regs.sv
// Self-checking bench for the channel 2 and bias drive register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cbd_config_regs;
   import cbd_pkg::*;
   // ==========================================
   // Signals and byte addresses
   localparam logic [7:0] A_CH2 = {CBD_IDX_CH2[5:0], 2'b00};
   localparam logic [7:0] A_BIAS = {CBD_IDX_BIAS[5:0], 2'b00};
   localparam logic [7:0] A_MCLK = {CBD_IDX_MCLK[5:0], 2'b00};
   localparam logic [7:0] A_STAT = {CBD_IDX_STAT[5:0], 2'b00};
   localparam logic [1:0] OK = CBD_RESP_OKAY;
   logic sys_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, lfsr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, gain;
   logic [1:0] bresp, rresp;
   logic [9:0] onehot;
   logic pd, posb, negb, third, bufon, loff, b2n, b2p, b1n, b1p, mclk, chop;
   logic [33:0] exp_q[$];
   int err_count, n_checks, rd_lag;
   logic [3:0] gtab [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hc, 4'h0};

   cbd_config_regs DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .chan2_powerdown(pd),
      .chan2_gain(gain), .chan2_mux_onehot(onehot), .chan2_pos_to_bias_pin(posb),
      .chan2_neg_to_bias_pin(negb), .chan2_route_third_pair(third),
      .bias_buffer_power_on(bufon), .bias_leadoff_sense_enable(loff),
      .bias_from_ch2_negative(b2n), .bias_from_ch2_positive(b2p),
      .bias_from_ch1_negative(b1n), .bias_from_ch1_positive(b1p),
      .modulator_clock(mclk), .chop_clock(chop));

   // Free running clock, 4 ns period
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ==========================================
   // Helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic nores(input string n);
      err_count++;
      $display("CHECK FAILED %s: expected response, seen none", n);
   endtask

   task automatic done_test(input string n);
      $display("Test %s finished", n);
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Bus write; upper byte lanes carry noise the block must ignore
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] r);
      bit aw = 0;
      bit w = 0;
      bit bd = 0;
      exp_q.push_back({r, 32'h0});
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= {lfsr, lfsr, lfsr, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int t = 0; t < 40 && !bd; t++) begin
         @(negedge sys_clk);
         aw |= awready;
         w |= wready;
         bd = bvalid;
         @(posedge sys_clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (bd) bready <= 1'b0;
      end
      if (!bd) nores("write");
   endtask

   // Bus read, expected word noted for the monitor; rready may lag rd_lag edges
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ar = 0;
      bit rdn = 0;
      exp_q.push_back({r, d});
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (rd_lag == 0);
      for (int t = 0; t < 40 && !rdn; t++) begin
         @(negedge sys_clk);
         ar |= arready;
         rdn = rvalid && rready;
         @(posedge sys_clk);
         if (ar) arvalid <= 1'b0;
         if (rdn) rready <= 1'b0;
         else if (t + 1 >= rd_lag) rready <= 1'b1;
      end
      if (!rdn) nores("read");
   endtask

   // Cycles between the second and third rising edge of a clock output
   task automatic period(input bit sel, output logic [33:0] n);
      int k = 0;
      logic c;
      logic p;
      n = 34'h0;
      p = sel ? chop : mclk;
      for (int t = 0; t < 900 && k < 3; t++) begin
         @(negedge sys_clk);
         c = sel ? chop : mclk;
         if (k == 2) n++;
         if (c && !p) k++;
         p = c;
      end
   endtask

   // ==========================================
   // Monitor: settled handshakes seen at the falling edge
   always @(negedge sys_clk) begin
      if (bvalid && bready) begin
         if (exp_q.size() == 0) nores("unexpected write answer");
         else chk("write response", exp_q.pop_front(), {bresp, 32'h0});
      end
      if (rvalid && rready) begin
         if (exp_q.size() == 0) nores("unexpected read answer");
         else chk("read data", exp_q.pop_front(), {rresp, rdata});
      end
   end

   // Watchdog, generous against about a thousand cycles of traffic
   initial begin
      #80000;
      nores("watchdog");
      finish_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      logic [7:0] v;
      logic [33:0] n;
      logic c;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      lfsr = 8'h3d;
      sys_rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(negedge sys_clk);
      chk("ready after reset", 34'h7, {awready, wready, arready});
      rd(A_CH2, 32'h0, OK);
      rd(A_BIAS, 32'h0, OK);
      chk("gain", 34'h6, gain);
      chk("mux", 34'h1, onehot);
      chk("bias bits", 34'h0, {pd, bufon, loff, b2n, b2p, b1n, b1p});
      done_test("reset");
      // Every gain and select code, readback alongside
      for (int i = 0; i < 16; i++) begin
         v = {1'b0, i[2:0], i[3:0]};
         wr(A_CH2, v, 4'hf, OK);
         rd(A_CH2, {24'h0, v}, OK);
         chk("gain", gtab[i % 8], gain);
         chk("mux", (i < 10) ? (10'h1 << i) : 10'h0, onehot);
         chk("bias pin", {i == 6 || i == 8, i == 7 || i == 8}, {posb, negb});
         chk("third pair", i == 9, third);
      end
      done_test("channel 2 codes");
      // Short inputs first, then power down and back up
      for (int p = 0; p < 3; p++) begin
         v = {p == 1, 3'h0, CBD_MUX_SHORT};
         wr(A_CH2, v, 4'hf, OK);
         rd(A_CH2, {24'h0, v}, OK);
         chk("powerdown", p == 1, pd);
      end
      wr(A_CH2, 8'hff, 4'h0, OK);
      rd(A_CH2, 32'h01, OK);
      done_test("power down");
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         v = lfsr;
         wr(A_BIAS, v, 4'h1, OK);
         rd(A_BIAS, {24'h0, v}, OK);
         chk("bias bits", v[5:0], {bufon, loff, b2n, b2p, b1n, b1p});
      end
      done_test("bias bits");
      // Divider and chop rates
      wr(A_BIAS, {CBD_CHOP_16, 6'h0}, 4'h1, OK);
      period(1'b0, n);
      chk("modulator period", 34'h4, n);
      period(1'b1, n);
      chk("chop period", 34'h40, n);
      wr(A_BIAS, {CBD_CHOP_2, 6'h0}, 4'h1, OK);
      period(1'b1, n);
      chk("chop period", 34'h8, n);
      wr(A_BIAS, {CBD_CHOP_4, 6'h0}, 4'h1, OK);
      period(1'b1, n);
      chk("chop period", 34'h10, n);
      wr(A_MCLK, 8'h01, 4'h1, OK);
      period(1'b0, n);
      chk("modulator period", 34'h10, n);
      period(1'b1, n);
      chk("chop period", 34'h40, n);
      wr(A_BIAS, 8'h40, 4'h1, OK);
      n = 34'h0;
      c = chop;
      repeat (200) begin
         @(negedge sys_clk);
         if (chop !== c) n++;
         c = chop;
      end
      chk("reserved chop toggles", 34'h0, n);
      wr(A_MCLK, 8'h00, 4'h1, OK);
      done_test("clocks");
      // Unmapped and read-only places leave the bank untouched
      wr(8'h3c, 8'h5a, 4'h1, CBD_RESP_SLVERR);
      rd(8'h3c, 32'h0, CBD_RESP_SLVERR);
      wr(A_STAT, 8'h5a, 4'h1, OK);
      rd(A_CH2, 32'h01, OK);
      rd_lag = 3; // Answer must stand while rready is held back
      rd(A_BIAS, 32'h40, OK);
      done_test("decode");
      repeat (4) @(posedge sys_clk);
      finish_test();
   end
endmodule
`default_nettype wire
